// ### inc/tsd_pkg.sv
// Purpose: shared constants and types of the dual target serial slave
// Assumes: 125 MHz core clock
// Notes:   times are kept in ms and converted to clock cycles here
package tsd_pkg;

  // ****************************************
  // timing
  // ****************************************
  localparam int unsigned CLK_HZ        = 125_000_000;
  localparam int unsigned TIMEOUT_MS    = 25;  // least stuck clock low time
  localparam int unsigned NV_WRITE_MS   = 5;   // nv_write_cycle_time
  localparam int unsigned FIRST_READ_MS = 100; // first_reading_delay
  localparam int unsigned TIMEOUT_CYC   = TIMEOUT_MS * (CLK_HZ / 1000);
  localparam int unsigned NV_WRITE_CYC  = NV_WRITE_MS * (CLK_HZ / 1000);
  localparam int unsigned FIRST_CYC     = FIRST_READ_MS * (CLK_HZ / 1000);
  localparam int unsigned CNT_W         = 24;

  // ****************************************
  // address byte fields
  // ****************************************
  localparam logic [3:0] PRE_SENSOR = 4'h3;
  localparam logic [3:0] PRE_MEMORY = 4'hA;
  localparam int unsigned PRE_LSB   = 4;
  localparam int unsigned STRAP_LSB = 1;
  localparam int unsigned RW_BIT    = 0;

  // ****************************************
  // sensor register pointers and fields
  // ****************************************
  localparam logic [7:0]  PTR_CFG    = 8'h01;
  localparam logic [7:0]  PTR_UPPER  = 8'h02;
  localparam logic [7:0]  PTR_LOWER  = 8'h03;
  localparam logic [7:0]  PTR_TEMP   = 8'h05;
  localparam int unsigned CFG_ALM_EN = 3;
  localparam int unsigned CFG_SHDN   = 8;
  localparam logic [15:0] CFG_RST    = 16'h0000;
  localparam logic [15:0] UPPER_RST  = 16'h0000;
  localparam logic [15:0] LOWER_RST  = 16'h0000;

  // ****************************************
  // types
  // ****************************************
  typedef enum logic [6:0] {
    TSD_IDLE   = 7'b0000001,
    TSD_ADDR   = 7'b0000010,
    TSD_ACK    = 7'b0000100,
    TSD_RX     = 7'b0001000,
    TSD_TX     = 7'b0010000,
    TSD_TXACK  = 7'b0100000,
    TSD_IGNORE = 7'b1000000
  } tsd_state_e;

  typedef struct packed {
    logic       wr;
    logic [7:0] addr;
    logic [7:0] data;
  } tsd_mem_wr_s;

  typedef struct packed {
    logic       o;
    logic       oe_n;
  } tsd_od_s;

endpackage

// ### rtl/tsd_sync.sv
// Purpose: two flip-flop synchroniser for pins from outside the clock domain
// Assumes: inputs are asynchronous levels
// Notes:   only the second stage may be read by other logic
`timescale 1ns/1ps
module tsd_sync #(
  parameter int unsigned W = 5
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         arst_n,
  // pins
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } tsd_sync_s;

  tsd_sync_s r_reg;
  tsd_sync_s r_next;

  always_comb
  begin
    r_next    = r_reg;
    r_next.s1 = d;
    r_next.s2 = r_reg.s1;
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      r_reg <= '0;
    else
      r_reg <= r_next;
  end

  assign q = r_reg.s2;

endmodule // tsd_sync

// ### rtl/tsd_slave.sv
// Purpose: two-wire slave front end of a sensor plus serial memory device
// Assumes: serial clock well below core clock; pads hold pull-downs on straps
// Notes:   sensor temperature and memory read data come from the user side
`timescale 1ns/1ps
module tsd_slave #(
  parameter int unsigned TO_CYC      = tsd_pkg::TIMEOUT_CYC,
  parameter int unsigned NV_CYC      = tsd_pkg::NV_WRITE_CYC,
  parameter int unsigned PU_CYC      = tsd_pkg::FIRST_CYC,
  parameter bit          MEM_TIMEOUT = 1'b1
) (
  // clock and reset
  input  wire logic                clk,
  input  wire logic                arst_n,
  // bus pins
  input  wire logic                scl_i,
  input  wire logic                sda_i,
  output tsd_pkg::tsd_od_s         sda,
  // address straps
  input  wire logic                strap_bit_zero,
  input  wire logic                strap_bit_one,
  input  wire logic                strap_bit_two,
  // alarm pin
  output tsd_pkg::tsd_od_s         alarm,
  // thermal_section user side
  input  wire logic signed [15:0]  temp_in,
  output logic                     temp_ready,
  output logic                     conv_run,
  // presence_memory user side
  output tsd_pkg::tsd_mem_wr_s     mem_wr,
  output logic [7:0]               mem_addr,
  input  wire logic [7:0]          mem_rdata,
  output logic                     nv_busy
);

  // ****************************************
  // parameter check
  // ****************************************
  if (TO_CYC < 2 || TO_CYC >= 2**tsd_pkg::CNT_W || NV_CYC < 1 || NV_CYC >= 2**tsd_pkg::CNT_W
      || PU_CYC < 2 || PU_CYC >= 2**tsd_pkg::CNT_W)
  begin : g_bad
    $error("tsd_slave: count parameter out of range");
  end

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    tsd_pkg::tsd_state_e       st;
    logic                      active;
    logic                      tgt_mem;
    logic                      rw;
    logic [3:0]                cnt;
    logic [7:0]                sh;
    logic [1:0]                bidx;
    logic                      half;
    logic [7:0]                ptr;
    logic [15:0]               wdat;
    logic                      pend;
    logic                      sda_drv;
    logic                      ack_ok;
    logic [tsd_pkg::CNT_W-1:0] to_cnt;
    logic [tsd_pkg::CNT_W-1:0] nv_cnt;
    logic [tsd_pkg::CNT_W-1:0] pu_cnt;
    logic                      ready;
    logic                      scl_q;
    logic                      sda_q;
    logic [15:0]               cfg;
    logic [15:0]               upper;
    logic [15:0]               lower;
    logic                      evt;
    tsd_pkg::tsd_mem_wr_s      mw;
  } tsd_core_s;

  tsd_core_s  r_reg;
  tsd_core_s  r_next;
  logic [4:0] pins;
  logic       scl;
  logic       sda_s;
  logic [2:0] strap;
  logic       rise;
  logic       fall;
  logic       start;
  logic       stop;
  logic       to_hit;
  logic       match;
  logic [3:0] pre;
  logic [7:0] txb;

  tsd_sync #(
    .W (5)
  ) u_sync (
    .clk    (clk),
    .arst_n (arst_n),
    .d      ({strap_bit_two, strap_bit_one, strap_bit_zero, sda_i, scl_i}),
    .q      (pins)
  );

  // ****************************************
  // bus events
  // ****************************************
  assign scl   = pins[0];
  assign sda_s = pins[1];
  assign strap = pins[4:2];
  assign rise  = scl & ~r_reg.scl_q;
  assign fall  = ~scl & r_reg.scl_q;
  assign start = r_reg.scl_q & scl & r_reg.sda_q & ~sda_s;
  assign stop  = r_reg.scl_q & scl & ~r_reg.sda_q & sda_s;
  assign to_hit = r_reg.active && !scl && (r_reg.to_cnt == tsd_pkg::CNT_W'(TO_CYC - 1))
                  && (MEM_TIMEOUT || !(r_reg.tgt_mem && r_reg.st != tsd_pkg::TSD_ADDR));
  assign pre   = r_reg.sh[tsd_pkg::PRE_LSB +: 4];
  assign match = (r_reg.sh[tsd_pkg::STRAP_LSB +: 3] == strap)
                 && (pre == tsd_pkg::PRE_SENSOR || (pre == tsd_pkg::PRE_MEMORY && r_reg.nv_cnt == '0));

  // byte to transmit: memory data, or sensor register high then low half
  always_comb
  begin
    txb = 8'h00;
    if (r_reg.tgt_mem)
      txb = mem_rdata;
    else if (r_reg.ptr == tsd_pkg::PTR_CFG)
      txb = r_reg.half ? r_reg.cfg[7:0] : r_reg.cfg[15:8];
    else if (r_reg.ptr == tsd_pkg::PTR_UPPER)
      txb = r_reg.half ? r_reg.upper[7:0] : r_reg.upper[15:8];
    else if (r_reg.ptr == tsd_pkg::PTR_LOWER)
      txb = r_reg.half ? r_reg.lower[7:0] : r_reg.lower[15:8];
    else if (r_reg.ptr == tsd_pkg::PTR_TEMP)
      txb = r_reg.half ? temp_in[7:0] : temp_in[15:8];
  end

  // ****************************************
  // next state
  // ****************************************
  always_comb
  begin
    r_next       = r_reg;
    r_next.mw.wr = 1'b0;
    r_next.scl_q = scl;
    r_next.sda_q = sda_s;
    if (!r_reg.ready)
    begin
      if (r_reg.pu_cnt == tsd_pkg::CNT_W'(PU_CYC - 1))
        r_next.ready = 1'b1;
      else
        r_next.pu_cnt = r_reg.pu_cnt + 1'b1;
    end
    if (r_reg.nv_cnt != '0)
      r_next.nv_cnt = r_reg.nv_cnt - 1'b1;
    r_next.evt = r_reg.cfg[tsd_pkg::CFG_ALM_EN] && r_reg.ready
                 && (temp_in > $signed(r_reg.upper) || temp_in < $signed(r_reg.lower));
    if (start)
    begin
      r_next.st      = tsd_pkg::TSD_ADDR;
      r_next.active  = 1'b1;
      r_next.cnt     = 4'h0;
      r_next.sda_drv = 1'b0;
      r_next.to_cnt  = '0;
      r_next.bidx    = 2'd0;
      r_next.half    = 1'b0;
      r_next.pend    = 1'b0;
    end
    else if (stop)
    begin
      r_next.st      = tsd_pkg::TSD_IDLE;
      r_next.active  = 1'b0;
      r_next.sda_drv = 1'b0;
      r_next.to_cnt  = '0;
      r_next.pend    = 1'b0;
      if (r_reg.pend && r_reg.tgt_mem)
      begin
        r_next.mw.wr   = 1'b1;
        r_next.mw.addr = r_reg.ptr;
        r_next.mw.data = r_reg.wdat[7:0];
        r_next.nv_cnt  = tsd_pkg::CNT_W'(NV_CYC);
      end
      else if (r_reg.pend)
      begin
        if (r_reg.ptr == tsd_pkg::PTR_CFG)
          r_next.cfg = r_reg.wdat;
        else if (r_reg.ptr == tsd_pkg::PTR_UPPER)
          r_next.upper = r_reg.wdat;
        else if (r_reg.ptr == tsd_pkg::PTR_LOWER)
          r_next.lower = r_reg.wdat;
      end
    end
    else if (to_hit)
    begin
      r_next.st      = tsd_pkg::TSD_IDLE;
      r_next.active  = 1'b0;
      r_next.sda_drv = 1'b0;
      r_next.to_cnt  = '0;
      r_next.pend    = 1'b0;
    end
    else
    begin
      if (fall || !r_reg.active)
        r_next.to_cnt = '0;
      else if (!scl)
        r_next.to_cnt = r_reg.to_cnt + 1'b1;
      case (r_reg.st)
        tsd_pkg::TSD_ADDR,
        tsd_pkg::TSD_RX:
        begin
          if (rise)
          begin
            r_next.sh  = {r_reg.sh[6:0], sda_s};
            r_next.cnt = r_reg.cnt + 1'b1;
          end
          else if (fall && r_reg.cnt == 4'd8)
          begin
            r_next.st      = tsd_pkg::TSD_ACK;
            r_next.sda_drv = 1'b1;
            if (r_reg.st == tsd_pkg::TSD_ADDR)
            begin
              r_next.tgt_mem = (pre == tsd_pkg::PRE_MEMORY);
              r_next.rw      = r_reg.sh[tsd_pkg::RW_BIT];
              if (!match)
              begin
                r_next.st      = tsd_pkg::TSD_IGNORE;
                r_next.sda_drv = 1'b0;
                r_next.active  = 1'b0;
              end
            end
            else
            begin
              r_next.bidx = (r_reg.bidx == 2'd3) ? 2'd3 : r_reg.bidx + 1'b1;
              if (r_reg.bidx == 2'd0)
                r_next.ptr = r_reg.sh;
              else if (r_reg.tgt_mem)
              begin
                r_next.wdat[7:0] = r_reg.sh;
                r_next.pend      = 1'b1;
              end
              else if (r_reg.bidx == 2'd1)
                r_next.wdat[15:8] = r_reg.sh;
              else if (r_reg.bidx == 2'd2)
              begin
                r_next.wdat[7:0] = r_reg.sh;
                r_next.pend      = 1'b1;
              end
            end
          end
        end
        tsd_pkg::TSD_ACK:
        begin
          if (fall)
          begin
            r_next.cnt = 4'h0;
            if (r_reg.rw)
            begin
              r_next.st      = tsd_pkg::TSD_TX;
              r_next.sh      = txb;
              r_next.sda_drv = ~txb[7];
            end
            else
            begin
              r_next.st      = tsd_pkg::TSD_RX;
              r_next.sda_drv = 1'b0;
            end
          end
        end
        tsd_pkg::TSD_TX:
        begin
          if (rise)
            r_next.cnt = r_reg.cnt + 1'b1;
          else if (fall && r_reg.cnt == 4'd8)
          begin
            r_next.st      = tsd_pkg::TSD_TXACK;
            r_next.sda_drv = 1'b0;
            r_next.half    = ~r_reg.half;
            if (r_reg.tgt_mem)
              r_next.ptr = r_reg.ptr + 1'b1;
          end
          else if (fall)
          begin
            r_next.sh      = {r_reg.sh[6:0], 1'b0};
            r_next.sda_drv = ~r_reg.sh[6];
          end
        end
        tsd_pkg::TSD_TXACK:
        begin
          if (rise)
            r_next.ack_ok = ~sda_s;
          else if (fall && r_reg.ack_ok)
          begin
            r_next.st      = tsd_pkg::TSD_TX;
            r_next.cnt     = 4'h0;
            r_next.sh      = txb;
            r_next.sda_drv = ~txb[7];
          end
          else if (fall)
          begin
            r_next.st      = tsd_pkg::TSD_IGNORE;
            r_next.sda_drv = 1'b0;
          end
        end
        default:
        begin
          r_next.sda_drv = 1'b0;
        end
      endcase
    end
  end

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      r_reg       <= '0;
      r_reg.st    <= tsd_pkg::TSD_IDLE;
      r_reg.scl_q <= 1'b1;
      r_reg.sda_q <= 1'b1;
      r_reg.cfg   <= tsd_pkg::CFG_RST;
      r_reg.upper <= tsd_pkg::UPPER_RST;
      r_reg.lower <= tsd_pkg::LOWER_RST;
    end
    else
      r_reg <= r_next;
  end

  // ****************************************
  // outputs
  // ****************************************
  assign sda.o      = 1'b0;
  assign sda.oe_n   = ~r_reg.sda_drv;
  assign alarm.o    = 1'b0;
  assign alarm.oe_n = ~r_reg.evt;
  assign temp_ready = r_reg.ready;
  assign conv_run   = ~r_reg.cfg[tsd_pkg::CFG_SHDN];
  assign mem_wr     = r_reg.mw;
  assign mem_addr   = r_reg.ptr;
  assign nv_busy    = (r_reg.nv_cnt != '0);

  // ****************************************
  // checks
  // ****************************************
  a_timeout_release: assert property (@(posedge clk) disable iff (!arst_n)
    to_hit && !start && !stop |=> r_reg.st == tsd_pkg::TSD_IDLE && !r_reg.sda_drv)
    else $error("timeout did not release the bus");
  a_timeout_idle: assert property (@(posedge clk) disable iff (!arst_n)
    !r_reg.active |=> r_reg.to_cnt == '0)
    else $error("timeout counter ran outside a transaction");
  a_start_addr: assert property (@(posedge clk) disable iff (!arst_n)
    start |=> r_reg.st == tsd_pkg::TSD_ADDR && r_reg.active && r_reg.cnt == 4'h0)
    else $error("start not taken");
  a_stop_idle: assert property (@(posedge clk) disable iff (!arst_n)
    stop && !start |=> r_reg.st == tsd_pkg::TSD_IDLE && !r_reg.sda_drv)
    else $error("stop did not end the transaction");
  a_ack_drive: assert property (@(posedge clk) disable iff (!arst_n)
    r_reg.st == tsd_pkg::TSD_ACK |-> r_reg.sda_drv)
    else $error("acknowledge slot not driven low");
  a_mismatch_quiet: assert property (@(posedge clk) disable iff (!arst_n)
    r_reg.st == tsd_pkg::TSD_IGNORE |-> !r_reg.sda_drv && sda.oe_n)
    else $error("data driven after mismatch");
  a_nack_release: assert property (@(posedge clk) disable iff (!arst_n)
    r_reg.st == tsd_pkg::TSD_TXACK && fall && !r_reg.ack_ok && !to_hit |=> ##1 sda.oe_n)
    else $error("still driving after no acknowledge");
  a_nv_launch: assert property (@(posedge clk) disable iff (!arst_n)
    r_reg.mw.wr |-> r_reg.nv_cnt == tsd_pkg::CNT_W'(NV_CYC) && nv_busy)
    else $error("memory write cycle not launched");
  a_first_reading: assert property (@(posedge clk) disable iff (!arst_n)
    $rose(r_reg.ready) |-> $past(r_reg.pu_cnt) == tsd_pkg::CNT_W'(PU_CYC - 1))
    else $error("first reading delay wrong");

endmodule // tsd_slave

// ### test/tsd_host.sv
// Purpose: behavioural bus master that drives the two-wire bus of the slave
// Assumes: the wire level is resolved outside, with a pull-up on the data line
// Notes:   one bit takes 16 clk; the serial clock stays low between calls, except after stop, which leaves it high
`timescale 1ns/1ps
module tsd_host (
  // clock
  input  wire logic clk,
  // bus
  input  wire logic sda_w,
  output logic      scl,
  output logic      sda_oe_n
);
  initial
  begin
    scl      = 1'b1;
    sda_oe_n = 1'b1;
  end

  // ****************************************
  // bus cycles
  // ****************************************
  // one quarter of a serial clock period
  task automatic drv(input logic c, input logic d);
    @(posedge clk);
    scl      <= c;
    sda_oe_n <= d;
    repeat (3) @(posedge clk);
  endtask

  // data released with the clock left where it is, then falls with clock high
  task automatic start;
    drv(scl, 1'b1);
    drv(1'b1, 1'b1);
    drv(1'b1, 1'b0);
    drv(1'b0, 1'b0);
  endtask

  task automatic stop;
    drv(1'b0, 1'b0);
    drv(1'b1, 1'b0);
    drv(1'b1, 1'b1);
  endtask

  // data changes only while the clock is low
  task automatic bit_out(input logic b);
    drv(1'b0, b);
    drv(1'b1, b);
    drv(1'b1, b);
    drv(1'b0, b);
  endtask

  task automatic bits8(input logic [7:0] b);
    for (int i = 7; i >= 0; i--)
      bit_out(b[i]);
  endtask

  // byte from the slave, then acknowledge (nack low) or no acknowledge
  task automatic recv(input logic nack, output logic [7:0] b);
    for (int i = 7; i >= 0; i--)
    begin
      drv(1'b0, 1'b1);
      drv(1'b1, 1'b1);
      b[i] = sda_w;
      drv(1'b1, 1'b1);
      drv(1'b0, 1'b1);
    end
    drv(1'b0, nack);
    drv(1'b1, nack);
    drv(1'b1, nack);
    drv(1'b0, nack);
  endtask

  // byte then acknowledge slot with the line released
  task automatic send(input logic [7:0] b, output logic ack);
    bits8(b);
    drv(1'b0, 1'b1);
    drv(1'b1, 1'b1);
    ack = ~sda_w;
    drv(1'b1, 1'b1);
    drv(1'b0, 1'b1);
  endtask
endmodule // tsd_host

// ### test/tb.sv
// Purpose: self-checking bench of the dual target serial slave
// Assumes: short timeout, write cycle and first reading counts
// Notes:   the bus master model sits in tsd_host
`timescale 1ns/1ps
module tb;
  localparam int unsigned TO = 200;
  localparam int unsigned NV = 300;
  localparam int unsigned PU = 20;
  logic                 clk;
  logic                 arst_n;
  logic                 scl;
  logic                 host_oe_n;
  wire logic            sda_w;
  logic [2:0]           strap;
  logic signed [15:0]   temp_in;
  logic signed [15:0]   upper;
  logic signed [15:0]   lower;
  logic signed [15:0]   t;
  logic [7:0]           mem_rdata;
  logic [7:0]           rb;
  logic [7:0]           mem_addr;
  logic                 temp_ready;
  logic                 conv_run;
  logic                 nv_busy;
  tsd_pkg::tsd_od_s     sda;
  tsd_pkg::tsd_od_s     alarm;
  tsd_pkg::tsd_mem_wr_s mem_wr;
  tsd_pkg::tsd_mem_wr_s last_wr;
  int                   wr_cnt;
  int                   failures;
  int                   check_count;
  int                   cyc;
  int                   n;

  // open-drain data wire with pull-up
  assign sda_w = host_oe_n & sda.oe_n;

  tsd_slave #(.TO_CYC(TO), .NV_CYC(NV), .PU_CYC(PU), .MEM_TIMEOUT(1'b1)) i_tsd_slave (
    .clk(clk), .arst_n(arst_n), .scl_i(scl), .sda_i(sda_w), .sda(sda),
    .strap_bit_zero(strap[0]), .strap_bit_one(strap[1]), .strap_bit_two(strap[2]),
    .alarm(alarm), .temp_in(temp_in), .temp_ready(temp_ready), .conv_run(conv_run),
    .mem_wr(mem_wr), .mem_addr(mem_addr), .mem_rdata(mem_rdata), .nv_busy(nv_busy)
  );

  tsd_host i_tsd_host (.clk(clk), .sda_w(sda_w), .scl(scl), .sda_oe_n(host_oe_n));

  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // write pulse monitor and run limit
  always @(posedge clk)
  begin
    cyc = cyc + 1;
    if (mem_wr.wr === 1'b1)
    begin
      wr_cnt  = wr_cnt + 1;
      last_wr = mem_wr;
    end
    if (cyc == 60000)
    begin
      failures = failures + 1;
      $display("MISMATCH %0t run did not finish", $time);
      summarize();
    end
  end

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic alarm_exp(input logic signed [15:0] v, input logic signed [15:0] u,
                                     input logic signed [15:0] l);
    return (v > u) || (v < l);
  endfunction

  task automatic chk(input logic ok, input string msg);
    check_count = check_count + 1;
    if (ok !== 1'b1)
    begin
      failures = failures + 1;
      $display("MISMATCH %0t %s", $time, msg);
    end
  endtask

  task automatic summarize;
    if (failures == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic rst_chk;
    chk(sda.oe_n === 1'b1 && alarm.oe_n === 1'b1 && temp_ready === 1'b0 && conv_run === 1'b1
        && nv_busy === 1'b0 && mem_wr.wr === 1'b0, "reset state");
  endtask

  task automatic wait_ready;
    n = 0;
    while (temp_ready !== 1'b1 && n < PU + 10)
    begin
      @(posedge clk);
      n = n + 1;
    end
    chk(n >= PU - 2 && n <= PU + 2, "first reading delay");
  endtask

  task automatic xfer(input logic [6:0] dev, input logic [7:0] p, input logic [15:0] d,
                      input int nd, input logic exp);
    logic a;
    i_tsd_host.start();
    i_tsd_host.send({dev, 1'b0}, a);
    chk(a === exp, "address acknowledge");
    i_tsd_host.send(p, a);
    chk(a === exp, "pointer acknowledge");
    if (nd == 2)
    begin
      i_tsd_host.send(d[15:8], a);
      chk(a === exp, "high byte acknowledge");
    end
    if (nd >= 1)
    begin
      i_tsd_host.send(d[7:0], a);
      chk(a === exp, "data acknowledge");
    end
    i_tsd_host.stop();
    repeat (4) @(posedge clk);
  endtask

  task automatic mem_write(input logic [7:0] p, input logic [7:0] d);
    int n0;
    n0 = wr_cnt;
    xfer({4'hA, strap}, p, {8'h00, d}, 1, 1'b1);
    chk(wr_cnt == n0 + 1 && last_wr.addr === p && last_wr.data === d, "memory write");
    chk(nv_busy === 1'b1, "write cycle started");
  endtask

  task automatic wait_idle;
    n = 0;
    while (nv_busy !== 1'b0 && n < NV + 10)
    begin
      @(posedge clk);
      n = n + 1;
    end
    chk(nv_busy === 1'b0, "write cycle ended");
  endtask

  // ****************************************
  // stimulus
  // ****************************************
  initial
  begin
    arst_n      = 1'b0;
    strap       = 3'h0;
    temp_in     = 16'sh0000;
    mem_rdata   = 8'h00;
    failures    = 0;
    check_count = 0;
    cyc         = 0;
    wr_cnt      = 0;
    void'($urandom(32'hC2589DB1));
    @(posedge clk);
    strap <= 3'($urandom());
    repeat (20) @(posedge clk);
    rst_chk();
    arst_n <= 1'b1;
    wait_ready();
    // matching address without a start is ignored
    i_tsd_host.send({4'hA, strap, 1'b0}, t[0]);
    chk(t[0] === 1'b0, "no start");
    i_tsd_host.stop();
    for (int k = 0; k < 6; k++)
    begin
      @(posedge clk);
      mem_rdata <= 8'($urandom());
      mem_write(8'($urandom()), 8'($urandom()));
      if (k == 0)
        xfer({4'hA, strap}, 8'h00, 16'h0000, 1, 1'b0);
      wait_idle();
    end
    n = wr_cnt;
    for (int p = 0; p < 16; p++)
      if (p != 3 && p != 10)
        xfer({4'(p), strap}, 8'h11, 16'h0022, 1, 1'b0);
    for (int b = 0; b < 3; b++)
      xfer({4'hA, strap ^ (3'h1 << b)}, 8'h11, 16'h0022, 1, 1'b0);
    chk(wr_cnt == n, "ignored writes");
    // start inside a byte aborts it
    i_tsd_host.start();
    i_tsd_host.bit_out(1'b1);
    i_tsd_host.bit_out(1'b0);
    i_tsd_host.bit_out(1'b1);
    mem_write(8'hFF, 8'h00);
    wait_idle();
    upper = 16'($urandom_range(0, 255));
    lower = upper - 16'sh0040;
    xfer({4'h3, strap}, tsd_pkg::PTR_UPPER, upper, 2, 1'b1);
    // read back the upper limit, high byte acknowledged, low byte not
    i_tsd_host.start();
    i_tsd_host.send({4'h3, strap, 1'b1}, t[0]);
    chk(t[0] === 1'b1, "read address acknowledge");
    i_tsd_host.recv(1'b0, rb);
    chk(rb === upper[15:8], "read high byte");
    i_tsd_host.recv(1'b1, rb);
    chk(rb === upper[7:0], "read low byte");
    i_tsd_host.stop();
    chk(sda.oe_n === 1'b1, "released after no acknowledge");
    xfer({4'h3, strap}, tsd_pkg::PTR_LOWER, lower, 2, 1'b1);
    xfer({4'h3, strap}, tsd_pkg::PTR_CFG, 16'h0008, 2, 1'b1);
    for (int i = 0; i < 10; i++)
    begin
      t = (i == 0) ? upper : (i == 1) ? lower : (i == 2) ? upper + 16'sh0001 :
          16'(int'(lower) - 50 + int'($urandom_range(0, 300)));
      @(posedge clk);
      temp_in <= t;
      repeat (6) @(posedge clk);
      chk(alarm.oe_n === ~alarm_exp(t, upper, lower), "alarm level");
    end
    xfer({4'h3, strap}, tsd_pkg::PTR_CFG, 16'h0108, 2, 1'b1);
    chk(conv_run === 1'b0, "shutdown committed at stop");
    xfer({4'h3, strap}, tsd_pkg::PTR_CFG, 16'h0008, 1, 1'b1);
    chk(conv_run === 1'b0, "half register write dropped");
    // clock stuck low during the acknowledge slot
    for (int j = 0; j < 2; j++)
    begin
      i_tsd_host.start();
      i_tsd_host.bits8({(j == 0) ? 4'h3 : 4'hA, strap, 1'b0});
      repeat (TO - 10) @(posedge clk);
      chk(sda.oe_n === 1'b0, "acknowledge held before timeout");
      repeat (30) @(posedge clk);
      chk(sda.oe_n === 1'b1, "released after timeout");
      i_tsd_host.stop();
    end
    mem_write(8'($urandom()), 8'($urandom()));
    @(posedge clk);
    arst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_chk();
    arst_n <= 1'b1;
    wait_ready();
    mem_write(8'h5A, 8'hA5);
    wait_idle();
    summarize();
  end
endmodule // tb
